//--- lud_consts.vh
// constants for the lin/uart data buffer block
// assumes 8-bit registers on 32-bit avalon words, one word per register
// What this block does
// - checksum mode latched on response command entry
// - buffer reached only via window, 3-bit index
// - index advances per window access when enabled
// - index wraps from 7 to 0
// - frame byte n stored at index n
// - uart mode: single unbuffered data register
// - uart write transmits, read returns last received
// - uart mode ignores buffer select register
// - debugger halt freezes controller and link index
// - soft reset bit self-clears, zero does nothing
// - version bit: 0 enhanced 2.1, 1 classic 1.3
// - command 010 rx response, 011 tx response
`ifndef LUD_CONSTS_VH
`define LUD_CONSTS_VH
// register indices, byte address = index * 4
`define LUD_IDX_CTRL 4'h0
`define LUD_IDX_STAT 4'h1
`define LUD_IDX_IRQEN 4'h2
`define LUD_IDX_ERR 4'h3
`define LUD_IDX_BTR 4'h4
`define LUD_IDX_BRRL 4'h5
`define LUD_IDX_BRRH 4'h6
`define LUD_IDX_DLR 4'h7
`define LUD_IDX_IDR 4'h8
`define LUD_IDX_SEL 4'h9
`define LUD_IDX_DAT 4'hA
`define LUD_IDX_CKS 4'hB
// control fields
`define LUD_CTRL_SWRES 7
`define LUD_CTRL_V13 6
`define LUD_CTRL_ENA 3
`define LUD_CTRL_UART 2
// buffer select fields
`define LUD_SEL_AINC 3
// commands
`define LUD_CMD_RXRSP 3'h2
`define LUD_CMD_TXRSP 3'h3
// reset values
`define LUD_BTR_RST 8'h20
`define LUD_ZERO8 8'h00
// soft reset length in cycles
`define LUD_SWRES_CYC 4'h4
`endif

//--- lud_data_buffer.v
// lin/uart data management: frame buffer, uart data register, control
// assumes avalon-mm master, link engine outside drives the rx/tx strobes
`timescale 1ns/1ps
`default_nettype none
`include "lud_consts.vh"
module lud_data_buffer (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire        dbg_halt,
	input  wire        lnk_rx_valid,
	input  wire [7:0]  lnk_rx_data,
	input  wire        lnk_tx_taken,
	input  wire        lnk_busy,
	input  wire [7:0]  lnk_status,
	input  wire [7:0]  lnk_error,
	output reg         uart_mode_r,
	output reg  [7:0]  control_r,
	output reg  [7:0]  tx_byte_r,
	output reg         tx_load_r,
	output reg  [2:0]  lnk_pos_r,
	output reg  [7:0]  lnk_tx_data_r,
	output reg         cks_enhanced_r,
	output reg         run_en_r,
	output reg         ctl_rst_r
);
	// register file
	reg [7:0] control_reg;
	reg [7:0] irq_enable_reg;
	reg [7:0] bit_timing_reg;
	reg [7:0] baud_divider_low;
	reg [7:0] baud_divider_high;
	reg [7:0] data_length_reg;
	reg [7:0] identifier_reg;
	reg [7:0] buffer_select_reg;
	reg [7:0] uart_rx_r;
	reg [7:0] frame_mem [0:7];
	reg       ack_r;
	reg [7:0] rd_nxt;
	wire      sw_busy;
	wire [3:0] reg_idx;
	wire      acc;
	wire      wr;
	wire      rd;
	wire      is_uart;
	wire [2:0] buffer_index;
	wire      auto_increment_disable;
	wire      sw_start;
	wire      halted;
	wire [2:0] cmd_new;
	wire      cmd_wr;

	// word address decode; byte address bits 1:0 ignored
	assign reg_idx = avs_address[5:2];
	assign acc = (avs_read | avs_write) & ~ack_r;
	assign wr = avs_write & ~ack_r;
	assign rd = avs_read & ~ack_r;
	assign is_uart = control_reg[`LUD_CTRL_UART];
	assign buffer_index = buffer_select_reg[2:0];
	assign auto_increment_disable = buffer_select_reg[`LUD_SEL_AINC];
	assign halted = dbg_halt;
	assign cmd_wr = wr && (reg_idx == `LUD_IDX_CTRL);
	assign cmd_new = avs_writedata[2:0];
	assign sw_start = cmd_wr & avs_writedata[`LUD_CTRL_SWRES];

	// index step with wrap, used for reads and writes
	function [2:0] next_index;
		input [2:0] cur;
		begin
			next_index = cur + 3'h1;
		end
	endfunction

	lud_sreset u_sreset (
		.ref_clk(ref_clk),
		.nrst   (nrst),
		.start  (sw_start),
		.busy_r (sw_busy)
	);

	// one wait state: ack on second cycle of every access
	always @(posedge ref_clk) begin
		if (!nrst) begin
			ack_r           <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_r           <= acc;
			avs_waitrequest <= ~acc;
		end
	end

	// read mux, unmapped indices read zero
	always @* begin
		rd_nxt = `LUD_ZERO8;
		case (reg_idx)
		`LUD_IDX_CTRL:  rd_nxt = control_reg;
		`LUD_IDX_STAT:  rd_nxt = lnk_status;
		`LUD_IDX_IRQEN: rd_nxt = {4'h0, irq_enable_reg[3:0]};
		`LUD_IDX_ERR:   rd_nxt = lnk_error;
		`LUD_IDX_BTR:   rd_nxt = bit_timing_reg;
		`LUD_IDX_BRRL:  rd_nxt = baud_divider_low;
		`LUD_IDX_BRRH:  rd_nxt = {4'h0, baud_divider_high[3:0]};
		`LUD_IDX_DLR:   rd_nxt = data_length_reg;
		`LUD_IDX_IDR:   rd_nxt = identifier_reg;
		`LUD_IDX_SEL:   rd_nxt = {4'h0, buffer_select_reg[3:0]};
		`LUD_IDX_DAT:   rd_nxt = is_uart ? uart_rx_r : frame_mem[buffer_index];
		`LUD_IDX_CKS:   rd_nxt = {7'h00, cks_enhanced_r};
		default:        rd_nxt = `LUD_ZERO8;
		endcase
	end

	// read data registered with the ack
	always @(posedge ref_clk) begin
		if (!nrst)
			avs_readdata <= 32'h0000_0000;
		else if (rd)
			avs_readdata <= {24'h000000, rd_nxt};
	end

	// register writes; soft reset restores defaults
	always @(posedge ref_clk) begin
		if (!nrst || sw_busy) begin
			control_reg       <= `LUD_ZERO8;
			irq_enable_reg    <= `LUD_ZERO8;
			bit_timing_reg    <= `LUD_BTR_RST;
			baud_divider_low  <= `LUD_ZERO8;
			baud_divider_high <= `LUD_ZERO8;
			data_length_reg   <= `LUD_ZERO8;
			identifier_reg    <= `LUD_ZERO8;
			buffer_select_reg <= `LUD_ZERO8;
		end else begin
			if (wr) begin
				case (reg_idx)
				`LUD_IDX_CTRL:  control_reg <= avs_writedata[7:0];
				`LUD_IDX_IRQEN: irq_enable_reg <= {4'h0, avs_writedata[3:0]};
				`LUD_IDX_BTR:   bit_timing_reg <= avs_writedata[7:0];
				`LUD_IDX_BRRL:  baud_divider_low <= avs_writedata[7:0];
				`LUD_IDX_BRRH:  baud_divider_high <= {4'h0, avs_writedata[3:0]};
				`LUD_IDX_DLR:   if (!is_uart) data_length_reg <= avs_writedata[7:0];
				`LUD_IDX_IDR:   identifier_reg <= {2'h0, avs_writedata[5:0]};
				`LUD_IDX_SEL:   buffer_select_reg <= {4'h0, avs_writedata[3:0]};
				default:        ;
				endcase
			end
			// index steps after window access in lin mode only
			if (acc && reg_idx == `LUD_IDX_DAT && !is_uart && !auto_increment_disable &&
			    !(wr && reg_idx == `LUD_IDX_SEL))
				buffer_select_reg[2:0] <= next_index(buffer_index);
		end
	end

	// frame buffer: software window and link side share the array
	always @(posedge ref_clk) begin
		if (wr && reg_idx == `LUD_IDX_DAT && !is_uart)
			frame_mem[buffer_index] <= avs_writedata[7:0];
		else if (nrst && lnk_rx_valid && !is_uart && !halted && !sw_busy)
			frame_mem[lnk_pos_r] <= lnk_rx_data;
	end

	// link position: restarts at index 0 for every response
	always @(posedge ref_clk) begin
		if (!nrst || sw_busy) begin
			lnk_pos_r     <= 3'h0;
			lnk_tx_data_r <= `LUD_ZERO8;
		end else if (cmd_wr && (cmd_new == `LUD_CMD_RXRSP || cmd_new == `LUD_CMD_TXRSP)) begin
			lnk_pos_r <= 3'h0;
		end else if (!halted && (lnk_rx_valid || lnk_tx_taken)) begin
			lnk_pos_r <= next_index(lnk_pos_r);
		end else begin
			lnk_tx_data_r <= frame_mem[lnk_pos_r];
		end
	end

	// uart single data register, no queue
	always @(posedge ref_clk) begin
		if (!nrst || sw_busy) begin
			uart_rx_r <= `LUD_ZERO8;
			tx_byte_r <= `LUD_ZERO8;
			tx_load_r <= 1'b0;
		end else begin
			tx_load_r <= 1'b0;
			if (is_uart && lnk_rx_valid && !halted)
				uart_rx_r <= lnk_rx_data;
			if (is_uart && wr && reg_idx == `LUD_IDX_DAT) begin
				tx_byte_r <= avs_writedata[7:0];
				tx_load_r <= 1'b1;
			end
		end
	end

	// checksum mode captured when a response command is entered
	always @(posedge ref_clk) begin
		if (!nrst || sw_busy)
			cks_enhanced_r <= 1'b1;
		else if (cmd_wr && avs_writedata[`LUD_CTRL_ENA] &&
		         (cmd_new == `LUD_CMD_RXRSP || cmd_new == `LUD_CMD_TXRSP))
			cks_enhanced_r <= ~avs_writedata[`LUD_CTRL_V13];
	end

	// controller outputs: freeze on halt, hold in reset during sequence
	always @(posedge ref_clk) begin
		if (!nrst) begin
			run_en_r    <= 1'b0;
			ctl_rst_r   <= 1'b1;
			uart_mode_r <= 1'b0;
			control_r   <= `LUD_ZERO8;
		end else begin
			run_en_r    <= ~halted & ~sw_busy & ~sw_start;
			ctl_rst_r   <= sw_busy | sw_start;
			uart_mode_r <= is_uart;
			control_r   <= control_reg;
		end
	end
endmodule // lud_data_buffer
`default_nettype wire

//--- lud_data_buffer_bench.sv
// self-checking bench for the lin/uart data buffer
// assumes lud_link_model on the link side, checker bound below
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module lud_data_buffer_bench;
	logic ref_clk, nrst, avs_read, avs_write, dbg_halt;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, lnk_rx_valid, lnk_tx_taken, lnk_busy, uart_mode_r, tx_load_r;
	wire cks_enhanced_r, run_en_r, ctl_rst_r;
	wire [7:0] lnk_rx_data, lnk_status, lnk_error, control_r, tx_byte_r, lnk_tx_data_r;
	wire [2:0] lnk_pos_r;
	int error_cnt, n_checks, k;
	logic [7:0] q;
	logic [2:0] p;
	// rows: register index, value expected after reset
	logic [11:0] rst_tab [13] = '{12'h000, 12'h15A, 12'h200, 12'h3C3, 12'h420, 12'h500,
		12'h600, 12'h700, 12'h800, 12'h900, 12'hB01, 12'hC00, 12'hF00};
	lud_data_buffer i_lud_data_buffer (.*);
	lud_link_model i_lud_link_model (.*);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		@(posedge ref_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		for (int n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin error_cnt++; conclude(); end
	endtask
	initial begin
		{nrst, avs_read, avs_write, dbg_halt} = 4'h0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		i_lud_link_model.set_flags(8'h5A, 8'hC3);
		for (k = 0; k < 13; k++) begin
			bus(0, rst_tab[k][11:8], 8'h00);
			`CHK("reset value", rst_tab[k][7:0], q)
		end
		$display("reset table done");
		// frame bytes land at 0,1; index runs 6,7 then wraps
		i_lud_link_model.rx_byte(8'h11);
		i_lud_link_model.rx_byte(8'h22);
		bus(1, 4'h9, 8'h06);
		bus(1, 4'hA, 8'h66);
		bus(1, 4'hA, 8'h77);
		bus(0, 4'hA, 8'h00);
		`CHK("wrap", 8'h11, q)
		bus(0, 4'hA, 8'h00);
		`CHK("second", 8'h22, q)
		bus(0, 4'h9, 8'h00);
		`CHK("index", 8'h02, q)
		bus(1, 4'h9, 8'h0F);
		bus(0, 4'hA, 8'h00);
		bus(0, 4'hA, 8'h00);
		`CHK("fixed", 8'h77, q)
		bus(0, 4'h9, 8'h00);
		`CHK("held", 8'h0F, q)
		$display("buffer test done");
		// both response commands with both version settings
		for (k = 0; k < 4; k++) begin
			bus(1, 4'h0, {1'b0, k[0], 3'b001, 2'b01, k[1]});
			`CHK("cks", !k[0], cks_enhanced_r)
		end
		bus(1, 4'h0, 8'h09);
		`CHK("cks kept", 1'b0, cks_enhanced_r)
		$display("checksum test done");
		bus(1, 4'h9, 8'h03);
		bus(1, 4'h0, 8'h0E);
		bus(1, 4'hA, 8'hC3);
		`CHK("tx", 8'hC3, tx_byte_r)
		`CHK("tx pulse", 1'b1, tx_load_r)
		i_lud_link_model.rx_byte(8'h96);
		i_lud_link_model.rx_byte(8'h69);
		bus(0, 4'hA, 8'h00);
		`CHK("rx", 8'h69, q)
		bus(0, 4'hA, 8'h00);
		`CHK("rx again", 8'h69, q)
		bus(0, 4'h9, 8'h00);
		`CHK("sel", 8'h03, q)
		$display("uart test done");
		// halt freezes the link index
		bus(1, 4'h0, 8'h08);
		p = lnk_pos_r;
		dbg_halt <= 1'b1;
		i_lud_link_model.rx_byte(8'h5C);
		i_lud_link_model.tx_take();
		`CHK("run", 1'b0, run_en_r)
		`CHK("frozen", p, lnk_pos_r)
		`CHK("ctl image", 8'h08, control_r)
		dbg_halt <= 1'b0;
		i_lud_link_model.rx_byte(8'h5D);
		@(posedge ref_clk);
		`CHK("moved", 3'(p + 3'h1), lnk_pos_r)
		$display("halt test done");
		// classic checksum for id 60 via version bit, tx bytes leave in index order
		bus(1, 4'h8, 8'h3C);
		bus(1, 4'h0, 8'h4B);
		`CHK("cks classic", 1'b0, cks_enhanced_r)
		@(posedge ref_clk);
		`CHK("tx data 0", 8'h11, lnk_tx_data_r)
		i_lud_link_model.tx_take();
		repeat (2) @(posedge ref_clk);
		`CHK("tx data 1", 8'h22, lnk_tx_data_r)
		$display("response test done");
		// soft reset clears itself and the registers
		bus(1, 4'h0, 8'hCA);
		repeat (2) @(posedge ref_clk);
		for (k = 0; k < 20 && ctl_rst_r !== 1'b0; k++) @(posedge ref_clk);
		`CHK("reset end", 1'b0, ctl_rst_r)
		bus(0, 4'h0, 8'h00);
		`CHK("ctrl", 8'h00, q)
		`CHK("ctl image idle", 8'h00, control_r)
		bus(0, 4'hB, 8'h00);
		`CHK("cks default", 8'h01, q)
		$display("soft reset test done");
		// hardware reset in mid-run returns registers to defaults
		bus(1, 4'h9, 8'h05);
		bus(1, 4'h0, 8'h4A);
		bus(1, 4'h0, 8'h0C);
		nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("rst ctl", 1'b1, ctl_rst_r)
		`CHK("rst run", 1'b0, run_en_r)
		`CHK("rst cks", 1'b1, cks_enhanced_r)
		nrst <= 1'b1;
		bus(0, 4'h9, 8'h00);
		`CHK("sel after rst", 8'h00, q)
		bus(0, 4'h0, 8'h00);
		`CHK("ctl after rst", 8'h00, q)
		`CHK("uart after rst", 1'b0, uart_mode_r)
		$display("hardware reset test done");
		conclude();
	end
endmodule // lud_data_buffer_bench
bind lud_data_buffer lud_props i_lud_props (.*);
`default_nettype wire

//--- lud_link_model.sv
// link side model: delivers received bytes, consumes transmit bytes
// assumes tasks are called after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module lud_link_model (
	input wire         ref_clk,
	output logic       lnk_rx_valid,
	output logic [7:0] lnk_rx_data,
	output logic       lnk_tx_taken,
	output wire        lnk_busy,
	output logic [7:0] lnk_status,
	output logic [7:0] lnk_error
);
	// busy is not used by the block, status and error images are settable
	assign lnk_busy = 1'b0;
	initial begin
		lnk_rx_valid = 1'b0;
		lnk_rx_data = 8'h00;
		lnk_tx_taken = 1'b0;
		lnk_status = 8'hA5;
		lnk_error = 8'h3C;
	end
	// new status and error images from the link engine
	task automatic set_flags(input logic [7:0] s, input logic [7:0] e);
		@(posedge ref_clk);
		lnk_status <= s;
		lnk_error <= e;
	endtask
	// one received byte, data line inverted once released
	task automatic rx_byte(input logic [7:0] b);
		@(posedge ref_clk);
		lnk_rx_valid <= 1'b1;
		lnk_rx_data <= b;
		@(posedge ref_clk);
		lnk_rx_valid <= 1'b0;
		lnk_rx_data <= ~b;
	endtask
	// one transmit byte consumed
	task automatic tx_take();
		@(posedge ref_clk);
		lnk_tx_taken <= 1'b1;
		@(posedge ref_clk);
		lnk_tx_taken <= 1'b0;
	endtask
endmodule // lud_link_model
`default_nettype wire

//--- lud_properties.sv
// port checker for the lin/uart data buffer
// assumes binding to lud_data_buffer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lud_props (
	input wire        ref_clk,
	input wire        nrst,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire        avs_waitrequest,
	input wire        dbg_halt,
	input wire        lnk_rx_valid,
	input wire        uart_mode_r,
	input wire [7:0]  tx_byte_r,
	input wire        tx_load_r,
	input wire [2:0]  lnk_pos_r,
	input wire        cks_enhanced_r,
	input wire        run_en_r,
	input wire        ctl_rst_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// request taken, control write decode
	wire req = (avs_read | avs_write) & avs_waitrequest;
	wire wr_ctl = req & avs_write & (avs_address[5:2] == 4'h0);
	ack_next_a: assert property (req |=> !avs_waitrequest) else $error("ack late");
	ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
	cks_latch_a: assert property (wr_ctl && avs_writedata[3] && avs_writedata[2:1] == 2'h1
		&& !avs_writedata[7] && !ctl_rst_r |=> cks_enhanced_r == !$past(avs_writedata[6]))
		else $error("checksum mode not latched");
	swres_start_a: assert property (wr_ctl && avs_writedata[7] |-> ##[1:2] ctl_rst_r)
		else $error("soft reset not started");
	swres_end_a: assert property ($rose(ctl_rst_r) |-> ##[3:6] !ctl_rst_r)
		else $error("soft reset not ended");
	rst_run_a: assert property (ctl_rst_r |-> !run_en_r) else $error("run in reset");
	halt_freeze_a: assert property (dbg_halt |=> !run_en_r && $stable(lnk_pos_r))
		else $error("halt did not freeze");
	pos_step_a: assert property (lnk_rx_valid && !dbg_halt && !uart_mode_r && !ctl_rst_r
		|=> lnk_pos_r == 3'($past(lnk_pos_r) + 3'h1)) else $error("link index step");
	uart_tx_a: assert property (req && avs_write && avs_address[5:2] == 4'hA && uart_mode_r
		|=> tx_load_r && tx_byte_r == $past(avs_writedata[7:0])) else $error("uart tx load");
	cover property (wr_ctl && avs_writedata[7]);
	cover property (tx_load_r);
	cover property (dbg_halt && lnk_rx_valid);
endmodule // lud_props
`default_nettype wire

//--- lud_sreset.v
// soft reset sequencer: stretches a start pulse into a fixed busy window
// assumes start is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "lud_consts.vh"
module lud_sreset (
	input  wire ref_clk,
	input  wire nrst,
	input  wire start,
	output reg  busy_r
);
	reg [3:0] cnt_r;
	// count down while busy, drop busy at zero
	always @(posedge ref_clk) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			cnt_r  <= 4'h0;
		end else if (start) begin
			busy_r <= 1'b1;
			cnt_r  <= `LUD_SWRES_CYC;
		end else if (busy_r) begin
			if (cnt_r == 4'h1)
				busy_r <= 1'b0;
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule // lud_sreset
`default_nettype wire
